// file: pkg/bsram_pkg.sv
package bsram_pkg;

    // ==========================================================
    // Widths and storage
    // ==========================================================
    localparam int DATA_W = 36;
    localparam int ADDR_W = 22;
    localparam int ROW_X18_W = 21;
    localparam int ROW_X36_W = 20;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int X18_LANES = 2;
    localparam int NIB_W = 4;
    localparam int X8_W = 8;
    localparam int STORE_AW = 4;
    localparam int STORE_DEPTH = 16;
    localparam int BANKS = 2;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {
        W_X8 = 2'h0,
        W_X9 = 2'h1,
        W_X18 = 2'h2,
        W_X36 = 2'h3
    } bsram_width_t;

    typedef enum logic [1:0] {
        L_IDLE = 2'h0,
        L_WDATA = 2'h1,
        L_WPOST = 2'h2
    } bsram_lst_t;

    typedef enum logic {
        E_IDLE = 1'h0,
        E_RESP = 1'h1
    } bsram_est_t;

    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] row;
        logic start;
        logic [DATA_W-1:0] d0;
        logic [DATA_W-1:0] d1;
        logic [DATA_W-1:0] m0;
        logic [DATA_W-1:0] m1;
    } bsram_txn_t;

    // ==========================================================
    // Helpers
    // ==========================================================
    // Active-high bit mask of the bits a beat may write.
    function automatic logic [DATA_W-1:0] bsram_mask(
        input bsram_width_t w,
        input logic nib0_n,
        input logic nib1_n,
        input logic [LANES-1:0] lane_n
    );
        logic [DATA_W-1:0] m;
        m = '0;
        case (w)
            W_X8:
            begin
                m[NIB_W-1:0] = {NIB_W{~nib0_n}};
                m[X8_W-1:NIB_W] = {NIB_W{~nib1_n}};
            end
            W_X9: m[LANE_W-1:0] = {LANE_W{~lane_n[0]}};
            W_X18:
            begin
                for (int i = 0; i < X18_LANES; i++)
                    m[i*LANE_W +: LANE_W] = {LANE_W{~lane_n[i]}};
            end
            default:
            begin
                for (int i = 0; i < LANES; i++)
                    m[i*LANE_W +: LANE_W] = {LANE_W{~lane_n[i]}};
            end
        endcase
        return m;
    endfunction : bsram_mask

    // Row address taken from the address pins used by each width.
    function automatic logic [ADDR_W-1:0] bsram_row(
        input bsram_width_t w,
        input logic [ADDR_W-1:0] a
    );
        case (w)
            W_X18: return ADDR_W'(a[ROW_X18_W-1:0]);
            W_X36: return ADDR_W'(a[ROW_X36_W-1:0]);
            default: return a;
        endcase
    endfunction : bsram_row

    function automatic logic [DATA_W-1:0] bsram_merge(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] d,
        input logic [DATA_W-1:0] m
    );
        return (old_w & ~m) | (d & m);
    endfunction : bsram_merge

endpackage : bsram_pkg

// file: hw/bsram_fifo2.sv
`timescale 1ns/100ps

module bsram_fifo2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    // ==========================================================
    // Storage and pointers
    // ==========================================================
    logic [WIDTH-1:0] data_reg [DEPTH];
    logic [WIDTH-1:0] data_next [DEPTH];
    logic wr_ptr_reg;
    logic wr_ptr_next;
    logic rd_ptr_reg;
    logic rd_ptr_next;
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic push;
    logic pop;

    assign in_ready = (count_reg != 2'(DEPTH));
    assign out_valid = (count_reg != 2'h0);
    assign out_data = data_reg[rd_ptr_reg];

    always_comb
    begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        data_next = data_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push)
        begin
            data_next[wr_ptr_reg] = in_data;
            wr_ptr_next = ~wr_ptr_reg;
        end
        if (pop)
            rd_ptr_next = ~rd_ptr_reg;
        if (push && !pop)
            count_next = count_reg + 2'h1;
        else if (pop && !push)
            count_next = count_reg - 2'h1;
    end

    always_ff @(posedge clk)
    begin
        data_reg <= data_next;
        if (reset)
        begin
            wr_ptr_reg <= 1'h0;
            rd_ptr_reg <= 1'h0;
            count_reg <= 2'h0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end

    chk_fifo_full_holds: assert property (@(posedge clk) disable iff (reset)
        (!in_ready && !out_ready) |=> !in_ready)
        else $error("fifo lost its full state without a pop");

    cov_fifo_full: cover property (@(posedge clk) disable iff (reset)
        !in_ready);

endmodule : bsram_fifo2

// file: hw/bsram_ddr_if.sv
`timescale 1ns/100ps

module bsram_ddr_if (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Link clock and width strap
    input wire logic link_k_clk,
    input wire logic [1:0] width_cfg,
    // Command and address
    input wire logic cycle_load_n,
    input wire logic rw_sel,
    input wire logic [bsram_pkg::ADDR_W-1:0] addr,
    input wire logic burst_start_bit,
    // Write selects
    input wire logic low_nibble_write_sel_n,
    input wire logic high_nibble_write_sel_n,
    input wire logic lane0_write_sel_n,
    input wire logic lane1_write_sel_n,
    input wire logic lane2_write_sel_n,
    input wire logic lane3_write_sel_n,
    // Data pin
    input wire logic [bsram_pkg::DATA_W-1:0] dq_in,
    output logic [bsram_pkg::DATA_W-1:0] dq_rise_out,
    output logic [bsram_pkg::DATA_W-1:0] dq_fall_out,
    output logic dq_oe,
    // Status
    output logic link_overrun
);

    // ==========================================================
    // Link domain synchronisers
    // ==========================================================
    // The link logic needs its clock running while reset is held.
    logic link_rst_s1;
    logic link_rst;
    logic [1:0] cfg_s1;
    logic [1:0] cfg_s2;
    logic ack_s1;
    logic ack_s2;
    logic resp_s1;
    logic resp_s2;
    logic ack_reg;
    logic resp_req_reg;
    bsram_pkg::bsram_width_t cfg;

    always_ff @(posedge link_k_clk)
    begin
        link_rst_s1 <= reset;
        link_rst <= link_rst_s1;
        cfg_s1 <= width_cfg;
        cfg_s2 <= cfg_s1;
        ack_s1 <= ack_reg;
        ack_s2 <= ack_s1;
        resp_s1 <= resp_req_reg;
        resp_s2 <= resp_s1;
    end

    assign cfg = bsram_pkg::bsram_width_t'(cfg_s2);

    // ==========================================================
    // Second beat capture
    // ==========================================================
    // Rising edge of the negative input clock is the falling edge here.
    logic [bsram_pkg::DATA_W-1:0] fall_d_reg;
    logic [bsram_pkg::DATA_W-1:0] fall_m_reg;
    logic [bsram_pkg::LANES-1:0] lane_n;

    assign lane_n = {lane3_write_sel_n, lane2_write_sel_n,
        lane1_write_sel_n, lane0_write_sel_n};

    always_ff @(negedge link_k_clk)
    begin
        fall_d_reg <= dq_in;
        fall_m_reg <= bsram_pkg::bsram_mask(cfg, low_nibble_write_sel_n,
            high_nibble_write_sel_n, lane_n);
    end

    // ==========================================================
    // Link command sequencer
    // ==========================================================
    bsram_pkg::bsram_lst_t lst_reg;
    bsram_pkg::bsram_lst_t lst_next;
    bsram_pkg::bsram_txn_t txn_reg;
    bsram_pkg::bsram_txn_t txn_next;
    logic req_reg;
    logic req_next;
    logic overrun_reg;
    logic overrun_next;
    logic [bsram_pkg::DATA_W-1:0] rd0_reg;
    logic [bsram_pkg::DATA_W-1:0] rd1_reg;
    logic [bsram_pkg::DATA_W-1:0] rise_reg;
    logic [bsram_pkg::DATA_W-1:0] rise_next;
    logic [bsram_pkg::DATA_W-1:0] fall_reg;
    logic [bsram_pkg::DATA_W-1:0] fall_next;
    logic oe_reg;
    logic oe_next;
    logic resp_ack_reg;
    logic resp_ack_next;
    logic busy;
    logic cmd;
    logic resp_pend;

    assign busy = (req_reg != ack_s2);
    assign cmd = !cycle_load_n;
    assign resp_pend = (resp_s2 != resp_ack_reg);

    always_comb
    begin
        lst_next = lst_reg;
        txn_next = txn_reg;
        req_next = req_reg;
        overrun_next = overrun_reg;
        rise_next = rise_reg;
        fall_next = fall_reg;
        oe_next = 1'h0;
        resp_ack_next = resp_ack_reg;
        case (lst_reg)
            bsram_pkg::L_IDLE:
            begin
                if (cmd && busy)
                    overrun_next = 1'h1;
                else if (cmd)
                begin
                    txn_next.row = bsram_pkg::bsram_row(cfg, addr);
                    txn_next.start = (cfg == bsram_pkg::W_X8 ||
                        cfg == bsram_pkg::W_X9) ? 1'h0 :
                        burst_start_bit;
                    txn_next.wr = !rw_sel;
                    txn_next.m0 = '0;
                    txn_next.m1 = '0;
                    if (rw_sel)
                        req_next = ~req_reg;
                    else
                        lst_next = bsram_pkg::L_WDATA;
                end
            end
            bsram_pkg::L_WDATA:
            begin
                if (cmd)
                    overrun_next = 1'h1;
                txn_next.d0 = dq_in;
                txn_next.m0 = bsram_pkg::bsram_mask(cfg,
                    low_nibble_write_sel_n, high_nibble_write_sel_n,
                    lane_n);
                lst_next = bsram_pkg::L_WPOST;
            end
            bsram_pkg::L_WPOST:
            begin
                if (cmd)
                    overrun_next = 1'h1;
                txn_next.d1 = fall_d_reg;
                txn_next.m1 = fall_m_reg;
                req_next = ~req_reg;
                lst_next = bsram_pkg::L_IDLE;
            end
            default: lst_next = bsram_pkg::L_IDLE;
        endcase
        // Read words are held stable by the core until acknowledged.
        if (resp_pend)
        begin
            rise_next = rd0_reg;
            fall_next = rd1_reg;
            oe_next = 1'h1;
            resp_ack_next = resp_s2;
        end
    end

    always_ff @(posedge link_k_clk)
    begin
        rise_reg <= rise_next;
        fall_reg <= fall_next;
        if (link_rst)
        begin
            lst_reg <= bsram_pkg::L_IDLE;
            txn_reg <= '0;
            req_reg <= 1'h0;
            overrun_reg <= 1'h0;
            oe_reg <= 1'h0;
            resp_ack_reg <= 1'h0;
        end
        else
        begin
            lst_reg <= lst_next;
            txn_reg <= txn_next;
            req_reg <= req_next;
            overrun_reg <= overrun_next;
            oe_reg <= oe_next;
            resp_ack_reg <= resp_ack_next;
        end
    end

    assign dq_rise_out = rise_reg;
    assign dq_fall_out = fall_reg;
    assign dq_oe = oe_reg;
    assign link_overrun = overrun_reg;

    // ==========================================================
    // Core side crossing and buffer
    // ==========================================================
    logic req_s1;
    logic req_s2;
    logic resp_ack_s1;
    logic resp_ack_s2;
    logic ack_next;
    logic bi_valid;
    logic bi_ready;
    logic bo_valid;
    logic bo_ready;
    bsram_pkg::bsram_txn_t bo;

    always_ff @(posedge clk_sys)
    begin
        req_s1 <= req_reg;
        req_s2 <= req_s1;
        resp_ack_s1 <= resp_ack_reg;
        resp_ack_s2 <= resp_ack_s1;
    end

    // Acknowledge waits for buffer room; until then further commands are dropped and set the overrun flag.
    assign bi_valid = (req_s2 != ack_reg);
    assign ack_next = (bi_valid && bi_ready) ? req_s2 : ack_reg;

    bsram_fifo2 #(
        .WIDTH($bits(bsram_pkg::bsram_txn_t)),
        .DEPTH(2)
    ) u_buf (
        .clk(clk_sys),
        .reset(reset),
        .in_valid(bi_valid),
        .in_ready(bi_ready),
        .in_data(txn_reg),
        .out_valid(bo_valid),
        .out_ready(bo_ready),
        .out_data(bo)
    );

    // ==========================================================
    // Storage engine
    // ==========================================================
    logic [bsram_pkg::DATA_W-1:0] mem_reg
        [bsram_pkg::BANKS][bsram_pkg::STORE_DEPTH];
    logic [bsram_pkg::DATA_W-1:0] mem_next
        [bsram_pkg::BANKS][bsram_pkg::STORE_DEPTH];
    bsram_pkg::bsram_est_t est_reg;
    bsram_pkg::bsram_est_t est_next;
    logic [bsram_pkg::DATA_W-1:0] rd0_next;
    logic [bsram_pkg::DATA_W-1:0] rd1_next;
    logic resp_req_next;
    logic [bsram_pkg::STORE_AW-1:0] idx;
    logic [bsram_pkg::DATA_W-1:0] even_word;
    logic [bsram_pkg::DATA_W-1:0] odd_word;
    logic fire;

    // Only the low row bits index the modelled storage window.
    assign idx = bo.row[bsram_pkg::STORE_AW-1:0];
    assign even_word = mem_reg[0][idx];
    assign odd_word = mem_reg[1][idx];
    assign fire = bo_valid && bo_ready;

    always_comb
    begin
        mem_next = mem_reg;
        rd0_next = rd0_reg;
        rd1_next = rd1_reg;
        resp_req_next = resp_req_reg;
        est_next = est_reg;
        bo_ready = (est_reg == bsram_pkg::E_IDLE);
        case (est_reg)
            bsram_pkg::E_IDLE:
            begin
                if (bo_valid && bo.wr)
                begin
                    mem_next[bo.start][idx] = bsram_pkg::bsram_merge(
                        mem_reg[bo.start][idx], bo.d0, bo.m0);
                    mem_next[~bo.start][idx] = bsram_pkg::bsram_merge(
                        mem_reg[~bo.start][idx], bo.d1, bo.m1);
                end
                else if (bo_valid)
                begin
                    rd0_next = mem_reg[bo.start][idx];
                    rd1_next = mem_reg[~bo.start][idx];
                    resp_req_next = ~resp_req_reg;
                    est_next = bsram_pkg::E_RESP;
                end
            end
            bsram_pkg::E_RESP:
            begin
                if (resp_ack_s2 == resp_req_reg)
                    est_next = bsram_pkg::E_IDLE;
            end
            default: est_next = bsram_pkg::E_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        mem_reg <= mem_next;
        rd0_reg <= rd0_next;
        rd1_reg <= rd1_next;
        if (reset)
        begin
            ack_reg <= 1'h0;
            resp_req_reg <= 1'h0;
            est_reg <= bsram_pkg::E_IDLE;
        end
        else
        begin
            ack_reg <= ack_next;
            resp_req_reg <= resp_req_next;
            est_reg <= est_next;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    chk_nibble_mask: assert property (@(posedge link_k_clk)
        disable iff (link_rst)
        (lst_reg == bsram_pkg::L_WDATA && cfg == bsram_pkg::W_X8) |=>
        (txn_reg.m0[bsram_pkg::DATA_W-1:bsram_pkg::X8_W] == '0 &&
        txn_reg.m0[0] == !$past(low_nibble_write_sel_n) &&
        txn_reg.m0[bsram_pkg::NIB_W] == !$past(high_nibble_write_sel_n)))
        else $error("nibble mask does not follow its selects");

    chk_lane_mask: assert property (@(posedge link_k_clk)
        disable iff (link_rst)
        (lst_reg == bsram_pkg::L_WDATA && cfg == bsram_pkg::W_X36) |=>
        (txn_reg.m0[bsram_pkg::DATA_W-1] == !$past(lane3_write_sel_n) &&
        txn_reg.m0[0] == !$past(lane0_write_sel_n)))
        else $error("lane mask does not follow its selects");

    chk_fall_beat: assert property (@(posedge link_k_clk)
        disable iff (link_rst)
        lst_reg == bsram_pkg::L_WPOST |=>
        (txn_reg.d1 == $past(fall_d_reg) && txn_reg.m1 == $past(fall_m_reg)))
        else $error("second beat not taken from falling edge");

    chk_addr_ignored: assert property (@(posedge link_k_clk)
        disable iff (link_rst)
        cycle_load_n |=> $stable(txn_reg.row) && $stable(txn_reg.wr))
        else $error("address taken without a load");

    chk_read_posted: assert property (@(posedge link_k_clk)
        disable iff (link_rst)
        (lst_reg == bsram_pkg::L_IDLE && cmd && rw_sel && !busy) |=>
        ($changed(req_reg) && !txn_reg.wr && lst_reg == bsram_pkg::L_IDLE))
        else $error("read load not posted at once");

    chk_write_seq: assert property (@(posedge link_k_clk)
        disable iff (link_rst)
        (lst_reg == bsram_pkg::L_IDLE && cmd && !rw_sel && !busy) |=>
        lst_reg == bsram_pkg::L_WDATA && $stable(req_reg) ##1
        lst_reg == bsram_pkg::L_WPOST ##1
        ($changed(req_reg) && lst_reg == bsram_pkg::L_IDLE))
        else $error("write burst not two beats long");

    chk_burst_zero: assert property (@(posedge link_k_clk)
        disable iff (link_rst)
        (lst_reg == bsram_pkg::L_IDLE && cmd && !busy &&
        (cfg == bsram_pkg::W_X8 || cfg == bsram_pkg::W_X9)) |=>
        !txn_reg.start)
        else $error("narrow burst did not start at word zero");

    chk_oe_read_only: assert property (@(posedge link_k_clk)
        disable iff (link_rst)
        dq_oe |-> $past(resp_pend) ##1 !dq_oe)
        else $error("outputs enabled outside one read");

    chk_wrap_read: assert property (@(posedge clk_sys) disable iff (reset)
        (fire && !bo.wr && bo.start) |=>
        (rd0_reg == $past(odd_word) && rd1_reg == $past(even_word)))
        else $error("burst from word one did not wrap");

    cov_read: cover property (@(posedge link_k_clk) disable iff (link_rst)
        dq_oe);
    cov_write: cover property (@(posedge link_k_clk) disable iff (link_rst)
        lst_reg == bsram_pkg::L_WPOST);
    cov_overrun: cover property (@(posedge link_k_clk) disable iff (link_rst)
        $rose(overrun_reg));
    cov_wrap_write: cover property (@(posedge clk_sys) disable iff (reset)
        fire && bo.wr && bo.start);

endmodule : bsram_ddr_if

// file: bench/bsram_ctrl_model.sv
`timescale 1ns/100ps

module bsram_ctrl_model (
    // Link clock
    input wire logic k_clk,
    // Command and address
    output logic load_n,
    output logic rw,
    output logic [bsram_pkg::ADDR_W-1:0] addr,
    output logic start,
    // Selects: high nibble, low nibble, lanes 3 to 0
    output logic [5:0] sel_n,
    // Write data
    output logic [bsram_pkg::DATA_W-1:0] dq
);
    // ==========================================================
    // Bus cycles
    // ==========================================================
    initial
    begin
        load_n = 1'b1;
        rw = 1'b1;
        addr = '0;
        start = 1'b0;
        sel_n = 6'h3f;
        dq = '0;
    end

    // Every pin but a held load is inverted after use, so late sampling reads garbage.
    task automatic cmd(input logic r, input logic [21:0] a, input logic s,
        input logic hold);
        @(negedge k_clk);
        load_n = 1'b0;
        rw = r;
        addr = a;
        start = s;
        @(negedge k_clk);
        load_n = ~hold;
        rw = ~r;
        addr = ~a;
        start = ~s;
    endtask : cmd

    // A clash keeps the load low into the first beat.
    task automatic wr(input logic [21:0] a, input logic s,
        input logic [35:0] d0, input logic [35:0] d1,
        input logic [5:0] s0, input logic [5:0] s1, input logic clash);
        cmd(1'b0, a, s, clash);
        dq = d0;
        sel_n = s0;
        @(posedge k_clk);
        #20;
        load_n = 1'b1;
        dq = d1;
        sel_n = s1;
        @(negedge k_clk);
        #10;
        dq = ~dq;
        sel_n = ~sel_n;
    endtask : wr
endmodule : bsram_ctrl_model

// file: bench/tb.sv
`timescale 1ns/100ps

module tb;
    // ==========================================================
    // Clocks, device and partner
    // ==========================================================
    logic clk_sys = 1'b0;
    logic link_k_clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] width_cfg = 2'h3;
    logic load_n, rw, start, oe, overrun;
    logic [21:0] addr;
    logic [5:0] sel_n;
    logic [35:0] dq, rise_q, fall_q;
    logic [35:0] exp_mem [2][16];
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    always #20 clk_sys = ~clk_sys;
    initial
    begin
        #13;
        forever #40 link_k_clk = ~link_k_clk;
    end

    bsram_ddr_if bsram_ddr_if_inst (.clk_sys(clk_sys), .reset(reset),
        .link_k_clk(link_k_clk), .width_cfg(width_cfg),
        .cycle_load_n(load_n), .rw_sel(rw), .addr(addr),
        .burst_start_bit(start), .low_nibble_write_sel_n(sel_n[4]),
        .high_nibble_write_sel_n(sel_n[5]), .lane0_write_sel_n(sel_n[0]),
        .lane1_write_sel_n(sel_n[1]), .lane2_write_sel_n(sel_n[2]),
        .lane3_write_sel_n(sel_n[3]), .dq_in(dq), .dq_rise_out(rise_q),
        .dq_fall_out(fall_q), .dq_oe(oe), .link_overrun(overrun));

    bsram_ctrl_model bsram_ctrl_model_inst (.k_clk(link_k_clk),
        .load_n(load_n), .rw(rw), .addr(addr), .start(start),
        .sel_n(sel_n), .dq(dq));

    // ==========================================================
    // Checks and helpers
    // ==========================================================
    task automatic check_word(input logic [35:0] got, input logic [35:0] e);
        num_checks++;
        if (got !== e)
        begin
            num_errors++;
            $display("[FAIL] %0t word %h expected %h", $time, got, e);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic e);
        num_checks++;
        if (got !== e)
        begin
            num_errors++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, e);
        end
    endtask : check_bit

    function automatic logic [35:0] sel_mask(input logic [5:0] s);
        logic [35:0] m;
        m = {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
        if (width_cfg == 2'h0)
            m = {28'h0, {4{~s[5]}}, {4{~s[4]}}};
        if (width_cfg == 2'h1)
            m[35:9] = '0;
        if (width_cfg == 2'h2)
            m[35:18] = '0;
        return m;
    endfunction : sel_mask

    task automatic set_width(input logic [1:0] w);
        @(negedge clk_sys);
        width_cfg = w;
        repeat (6) @(negedge link_k_clk);
    endtask : set_width

    task automatic do_wr(input logic [21:0] a, input logic s,
        input logic [35:0] d0, input logic [35:0] d1,
        input logic [5:0] s0, input logic [5:0] s1, input logic clash);
        logic [35:0] m0, m1;
        logic b;
        m0 = sel_mask(s0);
        m1 = sel_mask(s1);
        b = (width_cfg >= 2'h2) ? s : 1'b0;
        bsram_ctrl_model_inst.wr(a, s, d0, d1, s0, s1, clash);
        exp_mem[b][a[3:0]] = (exp_mem[b][a[3:0]] & ~m0) | (d0 & m0);
        exp_mem[~b][a[3:0]] = (exp_mem[~b][a[3:0]] & ~m1) | (d1 & m1);
        repeat (8) @(negedge link_k_clk);
        check_bit(oe, 1'b0);
    endtask : do_wr

    task automatic do_rd(input logic [21:0] a, input logic s);
        int n;
        logic b;
        b = (width_cfg >= 2'h2) ? s : 1'b0;
        bsram_ctrl_model_inst.cmd(1'b1, a, s, 1'b0);
        n = 0;
        while (oe !== 1'b1 && n < 40)
        begin
            @(negedge link_k_clk);
            n++;
        end
        check_bit(oe, 1'b1);
        check_word(rise_q, exp_mem[b][a[3:0]]);
        check_word(fall_q, exp_mem[~b][a[3:0]]);
        @(negedge link_k_clk);
        check_bit(oe, 1'b0);
    endtask : do_rd

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_full_x36;
        set_width(2'h3);
        do_wr(22'h3, 1'b0, 36'h1_2345_6789, 36'h9_8765_4321, 6'h30, 6'h30, 0);
        do_wr(22'h5, 1'b1, 36'hA_AAAA_5555, 36'h5_5555_AAAA, 6'h30, 6'h30, 0);
        do_rd(22'h3, 1'b0);
        do_rd(22'h5, 1'b1);
        do_rd(22'h5, 1'b0);
    endtask : t_full_x36

    // Each beat writes a different pair of lanes.
    task automatic t_lanes;
        do_wr(22'h3, 1'b0, 36'hF_FFFF_FFFF, 36'h0, 6'h35, 6'h3A, 0);
        do_rd(22'h3, 1'b0);
    endtask : t_lanes

    task automatic t_narrow;
        logic [35:0] d;
        for (int w = 0; w < 3; w++)
        begin
            set_width(w[1:0]);
            d = 36'h5_A5A5_A5A5 + 36'(w);
            do_wr(22'h5, 1'b1, d, ~d, 6'h1A, 6'h25, 0);
            do_rd(22'h5, 1'b1);
        end
    endtask : t_narrow

    task automatic t_overrun;
        set_width(2'h3);
        check_bit(overrun, 1'b0);
        do_wr(22'h7, 1'b0, 36'h0_1111_2222, 36'h3_3333_4444, 6'h30, 6'h30, 1);
        check_bit(overrun, 1'b1);
    endtask : t_overrun

    // ==========================================================
    // Run control
    // ==========================================================
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            num_errors++;
            close_out();
        end
    end

    // Reset is held long enough for the link domain to see it too.
    initial
    begin
        repeat (10) @(negedge clk_sys);
        reset = 1'b0;
        repeat (4) @(posedge link_k_clk);
        t_full_x36();
        t_lanes();
        t_narrow();
        t_overrun();
        close_out();
    end
endmodule : tb
